// *** bench/dual_uart_host_bus_port_tb.sv ***
// self-checking bench joining host end and device end
`timescale 1ns/1ps
module dual_uart_host_bus_port_tb;
  logic i_ref_clk = 1'b0; // 100 MHz
  logic i_arst_n = 1'b0;
  logic strobe_style = 1'b1; // bus style asked of the host
  logic req = 1'b0;
  logic wr = 1'b0;
  logic ch = 1'b0;
  logic [2:0] addr = 3'h0;
  logic [7:0] wdata = 8'h00;
  logic irq_a = 1'b0;
  logic irq_b = 1'b0;
  logic ready, done;
  logic [7:0] rdata, mcr_a, mcr_b;
  logic [7:0] mem [2][8]; // reference copy of both banks
  int n_mismatch = 0;
  int check_count = 0;
  int cycles = 0;
  int seed = 32'h717d1415;
  host_port_if hp();
  // long strobe so read data is driven before the host captures it
  host_port_host #(.STROBE_CYCLES(8), .GAP_CYCLES(2)) i_host_port_host (.i_ref_clk, .i_arst_n, .bus(hp.host),
    .i_strobe_style(strobe_style), .i_req(req), .i_write(wr), .i_chan(ch), .i_addr(addr), .i_wdata(wdata),
    .o_ready(ready), .o_done(done), .o_rdata(rdata));
  host_port_dev i_host_port_dev (.i_ref_clk, .i_arst_n, .bus(hp.dev), .i_chan_a_irq(irq_a),
    .i_chan_b_irq(irq_b), .o_chan_a_mcr(mcr_a), .o_chan_b_mcr(mcr_b));
  host_port_assertions i_chk (.i_ref_clk, .i_arst_n, .bus_sel(hp.bus_sel), .read_strobe_n(hp.read_strobe_n),
    .write_strobe_n(hp.write_strobe_n), .chan_a_select_n(hp.chan_a_select_n),
    .chan_b_select_n(hp.chan_b_select_n), .data_dev_oe(hp.data_dev_oe),
    .chan_a_interrupt_o(hp.chan_a_interrupt_o), .chan_a_interrupt_oe(hp.chan_a_interrupt_oe),
    .chan_b_interrupt_o(hp.chan_b_interrupt_o), .chan_b_interrupt_oe(hp.chan_b_interrupt_oe),
    .spare_output_a_n(hp.spare_output_a_n), .spare_output_b_n(hp.spare_output_b_n));
  // clock generator
  initial begin
    forever #5 i_ref_clk = ~i_ref_clk;
  end
  // hang guard: whole run needs a few thousand cycles
  always @(posedge i_ref_clk) begin
    cycles++;
    if (cycles == 20000) begin
      n_mismatch++;
      test_done();
    end
  end
  // compare one value against the model
  task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
    check_count++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("Error t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  // one host transfer; reads are compared, writes update the model
  task automatic xfer(input logic w, input logic c, input logic [2:0] a, input logic [7:0] d);
    do @(negedge i_ref_clk); while (ready !== 1'b1);
    @(posedge i_ref_clk);
    {req, wr, ch, addr, wdata} <= {1'b1, w, c, a, d};
    @(posedge i_ref_clk);
    req <= 1'b0;
    do @(negedge i_ref_clk); while (done !== 1'b1);
    if (w) mem[c][a] = d;
    else chk(rdata, mem[c][a]);
  endtask
  task automatic test_done();
    $display("checks %0d mismatches %0d", check_count, n_mismatch);
    if (n_mismatch == 0 && check_count > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask
  // main sequence: strobe style first, then line style
  initial begin
    foreach (mem[c, a]) mem[c][a] = 8'h00; // banks clear at reset
    repeat (20) @(posedge i_ref_clk);
    i_arst_n <= 1'b1;
    for (int s = 1; s >= 0; s--) begin
      @(posedge i_ref_clk);
      strobe_style <= s[0];
      repeat (12) @(posedge i_ref_clk); // let the device follow the style
      // every register of both banks: current model value (reset value on the strobe pass), random write, readback
      for (int i = 0; i < 16; i++) begin
        xfer(1'b0, i[3], i[2:0], 8'h00);
        xfer(1'b1, i[3], i[2:0], 8'($random(seed)));
        xfer(1'b0, i[3], i[2:0], 8'h00);
      end
      // second pass shows channel B writes left bank A alone
      for (int i = 0; i < 16; i++) xfer(1'b0, i[3], i[2:0], 8'h00);
      $display("bank test done, style %0d", s);
      // modem-control bit 3 per channel; line style keeps it set
      for (int m = 0; m < 4; m++) begin
        xfer(1'b1, 1'b0, 3'h4, {4'h0, m[0] | !s[0], 3'h0});
        xfer(1'b1, 1'b1, 3'h4, {4'h0, m[1] | !s[0], 3'h0});
        @(posedge i_ref_clk); // requests change on the rising edge only
        irq_a <= m[0];
        irq_b <= m[1];
        repeat (12) @(posedge i_ref_clk);
        @(negedge i_ref_clk);
        chk(mcr_a, mem[0][4]);
        chk(mcr_b, mem[1][4]);
        if (s) begin
          chk({7'h0, hp.spare_output_a_n}, {7'h0, !m[0]});
          chk({7'h0, hp.chan_a_interrupt_oe}, {7'h0, m[0]});
          chk({7'h0, hp.spare_output_b_n}, {7'h0, !m[1]});
          chk({7'h0, hp.chan_b_interrupt_oe}, {7'h0, m[1]});
        end else begin
          // pull-up resolves the released open-drain pin
          chk({7'h0, hp.chan_a_interrupt_oe ? hp.chan_a_interrupt_o : 1'b1}, {7'h0, !(m[0] | m[1])});
          chk({7'h0, hp.chan_b_interrupt_oe & hp.chan_b_interrupt_o}, 8'h00);
        end
      end
      $display("interrupt test done, style %0d", s);
    end
    test_done();
  end
endmodule

// *** bench/host_port_assertions.sv ***
// pin-level checks between the host end and the device end
`timescale 1ns/1ps
module host_port_assertions (
  input wire logic i_ref_clk,
  input wire logic i_arst_n,
  input wire logic bus_sel,
  input wire logic read_strobe_n,
  input wire logic write_strobe_n,
  input wire logic chan_a_select_n,
  input wire logic chan_b_select_n,
  input wire logic data_dev_oe,
  input wire logic chan_a_interrupt_o,
  input wire logic chan_a_interrupt_oe,
  input wire logic chan_b_interrupt_o,
  input wire logic chan_b_interrupt_oe,
  input wire logic spare_output_a_n,
  input wire logic spare_output_b_n
);
  default clocking @(posedge i_ref_clk); endclocking
  default disable iff (!i_arst_n);
  // style held long enough for the device synchroniser to follow it
  sequence s_strobe_mode; bus_sel [*8]; endsequence
  sequence s_line_mode; !bus_sel [*8]; endsequence
  // a selected read held for the full strobe, well past the sync lag
  sequence s_strobe_read; (bus_sel && !read_strobe_n && !(chan_a_select_n && chan_b_select_n)) [*8]; endsequence
  sequence s_line_read; (!bus_sel && !chan_a_select_n && write_strobe_n) [*8]; endsequence
  // no read pending in either style
  sequence s_no_read; ((bus_sel && read_strobe_n) || (!bus_sel && (chan_a_select_n || !write_strobe_n))) [*8]; endsequence
  a_strobe_read_drive: assert property (s_strobe_read |-> data_dev_oe)
    else $error("device silent during strobe read");
  a_line_read_drive: assert property (s_line_read |-> data_dev_oe)
    else $error("device silent during line read");
  a_bus_release: assert property (s_no_read |-> !data_dev_oe)
    else $error("data bus driven with no read");
  a_drive_cause: assert property ($rose(data_dev_oe) |->
    (bus_sel ? !read_strobe_n : (!chan_a_select_n && write_strobe_n)))
    else $error("device began driving without a read");
  a_irq_a_gate: assert property (s_strobe_mode |-> chan_a_interrupt_oe == !spare_output_a_n)
    else $error("channel a interrupt and spare disagree");
  a_irq_b_gate: assert property (s_strobe_mode |-> chan_b_interrupt_oe == !spare_output_b_n)
    else $error("channel b interrupt and spare disagree");
  a_line_open_drain: assert property (s_line_mode |-> !(chan_a_interrupt_oe && chan_a_interrupt_o))
    else $error("shared interrupt driven high");
  a_line_b_low: assert property (s_line_mode |-> !(chan_b_interrupt_oe && chan_b_interrupt_o))
    else $error("unused interrupt driven high");
endmodule

// *** hdl/host_port_dev.sv ***
// device end: pin decode, per-channel register banks, interrupt pins
`timescale 1ns/1ps
`include "host_port_params.svh"
// overview of the device end:
// - every host pin comes from outside this clock and passes the three-stage
//   synchroniser before any decode looks at it
// - the synchroniser holds a bit until stages two and three agree, so a
//   single-cycle glitch on a strobe never opens a transfer
// - the cost is latency: the device sees a pin roughly four cycles late, so
//   the host must hold a read strobe longer than that before capturing
// - the bus style pin is synchronised like the others; changing it in the
//   middle of a transfer is not supported and gives undefined decode
// - writes are two-phase: the opening edge records channel and address,
//   the closing edge stores the data byte seen on that same sample
// - reads drive the registered data one cycle after the decode sees them
// - all pin outputs come straight from flip-flops to keep them glitch free
module host_port_dev #(
  parameter int NUM_REGS = `HP_NUM_REGS
) (
  input wire logic i_ref_clk,
  input wire logic i_arst_n,
  host_port_if.dev bus,
  input wire logic i_chan_a_irq, // interrupt request from channel A logic
  input wire logic i_chan_b_irq, // interrupt request from channel B logic
  output logic [7:0] o_chan_a_mcr, // channel A modem-control copy
  output logic [7:0] o_chan_b_mcr // channel B modem-control copy
);
  // true while the decoded selects address either channel
  function automatic logic any_selected(input logic a, input logic b);
    // in strobe style both may be low; either one counts as a selected access
    any_selected = a || b;
  endfunction

  // synchronised pin levels: sel, rd, wr, csa, csb, addr[2:0], data[7:0]
  // packing them into one vector keeps a single synchroniser instance
  logic [15:0] pins_raw, pins;
  assign pins_raw = {bus.bus_sel, bus.read_strobe_n, bus.write_strobe_n, bus.chan_a_select_n,
                     bus.chan_b_select_n, bus.reg_addr, bus.data_host_o};
  pin_sync #(.WIDTH(16), .RESET_VAL(16'hf800)) u_sync (
    .i_ref_clk(i_ref_clk),
    .i_arst_n(i_arst_n),
    .i_pin(pins_raw),
    .o_level(pins)
  );
  // unpacked synchronised views of the pins
  logic sel; // bus style as seen by the device
  logic rd_n; // read strobe, unused in line style
  logic wr_n; // write strobe, or direction line in line style
  logic csa_n; // channel A select, or device select in line style
  logic csb_n; // channel B select, or channel bit in line style
  logic [2:0] addr; // register address within the channel
  logic [7:0] wdata; // byte the host drives during writes
  assign {sel, rd_n, wr_n, csa_n, csb_n, addr, wdata} = pins;

  // register banks, one per channel
  logic [7:0] regs_reg [2][NUM_REGS];
  logic [7:0] regs_next [2][NUM_REGS];
  logic wr_act_reg, wr_act_next; // write cycle in progress
  logic wr_ch_reg, wr_ch_next;
  logic [2:0] wr_addr_reg, wr_addr_next;
  logic [7:0] dout_reg, dout_next;
  logic doe_reg, doe_next;
  logic [1:0] irq_o_reg, irq_o_next, irq_oe_reg, irq_oe_next, spare_reg, spare_next;

  logic sel_a; // channel A addressed this cycle
  logic sel_b; // channel B addressed this cycle
  logic rd_req; // a read is asked for
  logic wr_req; // a write is asked for
  logic ch; // bank index: 0 channel A, 1 channel B
  // decode select, channel and direction for both styles
  // line style folds select and direction into one access strobe on the
  // device select, so read and write requests are both gated by it
  always_comb begin
    if (sel) begin
      sel_a = !csa_n; // [RL7]
      sel_b = !csb_n; // [RL7]
      rd_req = !rd_n; // [RL3]
      wr_req = !wr_n; // [RL4]
    end else begin
      sel_a = !csa_n && !csb_n; // [RL8] [RL9]
      sel_b = !csa_n && csb_n; // [RL9]
      rd_req = !csa_n && wr_n; // [RL6]
      wr_req = !csa_n && !wr_n; // [RL6]
    end
    ch = sel_b; // both selects in strobe style: channel B wins
  end

  // register update, read drive, interrupt pin state
  always_comb begin
    regs_next = regs_reg;
    wr_act_next = wr_act_reg;
    wr_ch_next = wr_ch_reg;
    wr_addr_next = wr_addr_reg;
    // write cycle opens on strobe fall, data lands on the rise
    // limitation: a write whose select drops before its strobe still lands,
    // since the closing edge is taken as the end of either qualifier
    if (wr_req && any_selected(sel_a, sel_b)) begin
      wr_act_next = 1'b1; // [RL4]
      wr_ch_next = ch;
      wr_addr_next = addr; // [RL1]
    end else if (wr_act_reg) begin
      wr_act_next = 1'b0;
      regs_next[wr_ch_reg][wr_addr_reg] = wdata; // [RL4]
    end
    // drive only during a selected read, released otherwise
    // releasing the bus outside reads keeps it free of contention with host writes
    doe_next = rd_req && any_selected(sel_a, sel_b); // [RL2] [RL14]
    dout_next = doe_next ? regs_reg[ch][addr] : 8'h00; // [RL1] [RL3]
    for (int c = 0; c < 2; c++) begin
      logic en;
      logic irq;
      en = regs_reg[c][`HP_MCR_ADDR][`HP_MCR_IRQ_EN_BIT];
      irq = (c == 0) ? i_chan_a_irq : i_chan_b_irq;
      spare_next[c] = !en; // [RL10] [RL11]
      irq_o_next[c] = irq; // [RL10] [RL13]
      irq_oe_next[c] = en; // [RL10] [RL11] [RL13]
    end
    // line style: one shared open-drain request, pulled low while any channel
    // asks; the unused channel B pin is held driven low
    if (!sel) begin
      irq_o_next[0] = 1'b0; // [RL12]
      irq_oe_next[0] = i_chan_a_irq || i_chan_b_irq; // [RL12]
      irq_o_next[1] = 1'b0; // [RL13]
      irq_oe_next[1] = 1'b1; // [RL13]
    end
  end

  // registers only
  // reset leaves the data bus and interrupt pins released and spares high,
  // which matches modem-control bit 3 being clear in every bank
  always_ff @(posedge i_ref_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      for (int c = 0; c < 2; c++) begin
        for (int r = 0; r < NUM_REGS; r++) begin
          regs_reg[c][r] <= `HP_REG_RESET;
        end
      end
      wr_act_reg <= 1'b0;
      wr_ch_reg <= 1'b0;
      wr_addr_reg <= 3'h0;
      dout_reg <= 8'h00;
      doe_reg <= 1'b0;
      irq_o_reg <= 2'h0;
      irq_oe_reg <= 2'h0;
      spare_reg <= 2'h3;
    end else begin
      regs_reg <= regs_next;
      wr_act_reg <= wr_act_next;
      wr_ch_reg <= wr_ch_next;
      wr_addr_reg <= wr_addr_next;
      dout_reg <= dout_next;
      doe_reg <= doe_next;
      irq_o_reg <= irq_o_next;
      irq_oe_reg <= irq_oe_next;
      spare_reg <= spare_next;
    end
  end

  // pin outputs, each straight from a flip-flop
  assign bus.data_dev_o = dout_reg;
  assign bus.data_dev_oe = doe_reg;
  assign bus.chan_a_interrupt_o = irq_o_reg[0];
  assign bus.chan_a_interrupt_oe = irq_oe_reg[0];
  assign bus.chan_b_interrupt_o = irq_o_reg[1];
  assign bus.chan_b_interrupt_oe = irq_oe_reg[1];
  assign bus.spare_output_a_n = spare_reg[0];
  assign bus.spare_output_b_n = spare_reg[1];
  // modem-control copies for the channel logic beyond this port
  assign o_chan_a_mcr = regs_reg[0][`HP_MCR_ADDR];
  assign o_chan_b_mcr = regs_reg[1][`HP_MCR_ADDR];
endmodule

// *** hdl/host_port_host.sv ***
// host end: runs one read or write transaction per request
`timescale 1ns/1ps
`include "host_port_params.svh"
module host_port_host #(
  parameter int STROBE_CYCLES = `HP_STROBE_CYCLES,
  parameter int GAP_CYCLES = `HP_GAP_CYCLES
) (
  input wire logic i_ref_clk,
  input wire logic i_arst_n,
  host_port_if.host bus,
  input wire logic i_strobe_style, // 1 strobe style, 0 line style
  input wire logic i_req, // one-cycle request when o_ready
  input wire logic i_write,
  input wire logic i_chan,
  input wire logic [2:0] i_addr,
  input wire logic [7:0] i_wdata,
  output logic o_ready,
  output logic o_done,
  output logic [7:0] o_rdata
);
  host_port_pkg::host_state_t st_reg, st_next;
  logic [7:0] cnt_reg, cnt_next;
  logic wr_reg, wr_next, ch_reg, ch_next;
  logic [2:0] a_reg, a_next;
  logic [7:0] wd_reg, wd_next, rd_reg, rd_next;
  logic done_reg, done_next, rdy_reg, rdy_next;
  logic sel_reg, sel_next;
  logic rs_reg, rs_next, ws_reg, ws_next, ca_reg, ca_next, cb_reg, cb_next, doe_reg, doe_next;
  // sequencer: setup, strobe low, capture at rise, gap
  always_comb begin
    st_next = st_reg;
    cnt_next = cnt_reg;
    wr_next = wr_reg;
    ch_next = ch_reg;
    a_next = a_reg;
    wd_next = wd_reg;
    rd_next = rd_reg;
    done_next = 1'b0;
    rdy_next = rdy_reg;
    sel_next = sel_reg;
    unique case (st_reg)
      host_port_pkg::st_idle: begin
        sel_next = i_strobe_style; // style only changes between transactions
        if (i_req && rdy_reg) begin
          wr_next = i_write;
          ch_next = i_chan;
          a_next = i_addr; // [RL1]
          wd_next = i_wdata;
          rdy_next = 1'b0;
          st_next = host_port_pkg::st_setup;
        end
      end
      host_port_pkg::st_setup: begin
        cnt_next = 8'(STROBE_CYCLES);
        st_next = host_port_pkg::st_strobe;
      end
      host_port_pkg::st_strobe: begin
        cnt_next = cnt_reg - 8'h01;
        if (cnt_reg == 8'h01) begin
          if (!wr_reg) begin
            rd_next = bus.data_dev_o; // [RL3]
          end
          done_next = 1'b1;
          cnt_next = 8'(GAP_CYCLES);
          st_next = host_port_pkg::st_gap;
        end
      end
      host_port_pkg::st_gap: begin
        cnt_next = cnt_reg - 8'h01;
        if (cnt_reg == 8'h01) begin
          rdy_next = 1'b1;
          st_next = host_port_pkg::st_idle;
        end
      end
    endcase
    // pin levels for the next cycle
    rs_next = 1'b1; // [RL5]
    ws_next = sel_next ? 1'b1 : 1'b1;
    ca_next = 1'b1;
    cb_next = 1'b1;
    doe_next = 1'b0;
    if (st_next == host_port_pkg::st_setup || st_next == host_port_pkg::st_strobe) begin
      doe_next = wr_next;
      if (sel_next) begin
        ca_next = ch_next; // [RL7]
        cb_next = !ch_next; // [RL7]
        if (st_next == host_port_pkg::st_strobe) begin
          rs_next = wr_next; // [RL3]
          ws_next = !wr_next; // [RL4]
        end
      end else begin
        ws_next = !wr_next; // [RL6]
        cb_next = ch_next; // [RL9]
        ca_next = (st_next != host_port_pkg::st_strobe); // [RL8]
      end
    end
  end
  // registers only
  always_ff @(posedge i_ref_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      st_reg <= host_port_pkg::st_idle;
      cnt_reg <= 8'h00;
      wr_reg <= 1'b0;
      ch_reg <= 1'b0;
      a_reg <= 3'h0;
      wd_reg <= 8'h00;
      rd_reg <= 8'h00;
      done_reg <= 1'b0;
      rdy_reg <= 1'b1;
      sel_reg <= 1'b1;
      rs_reg <= 1'b1;
      ws_reg <= 1'b1;
      ca_reg <= 1'b1;
      cb_reg <= 1'b1;
      doe_reg <= 1'b0;
    end else begin
      st_reg <= st_next;
      cnt_reg <= cnt_next;
      wr_reg <= wr_next;
      ch_reg <= ch_next;
      a_reg <= a_next;
      wd_reg <= wd_next;
      rd_reg <= rd_next;
      done_reg <= done_next;
      rdy_reg <= rdy_next;
      sel_reg <= sel_next;
      rs_reg <= rs_next;
      ws_reg <= ws_next;
      ca_reg <= ca_next;
      cb_reg <= cb_next;
      doe_reg <= doe_next;
    end
  end
  assign bus.bus_sel = sel_reg;
  assign bus.reg_addr = a_reg;
  assign bus.read_strobe_n = rs_reg;
  assign bus.write_strobe_n = ws_reg;
  assign bus.chan_a_select_n = ca_reg;
  assign bus.chan_b_select_n = cb_reg;
  assign bus.data_host_o = wd_reg;
  assign bus.data_host_oe = doe_reg;
  assign o_ready = rdy_reg;
  assign o_done = done_reg;
  assign o_rdata = rd_reg;
endmodule

// *** hdl/host_port_if.sv ***
// pin-level interface between the host and the dual-channel port
`timescale 1ns/1ps
interface host_port_if;
  logic bus_sel; // high strobe style, low line style
  logic [2:0] reg_addr;
  logic read_strobe_n;
  logic write_strobe_n;
  logic chan_a_select_n;
  logic chan_b_select_n;
  logic [7:0] data_host_o;
  logic data_host_oe;
  logic [7:0] data_dev_o;
  logic data_dev_oe;
  logic chan_a_interrupt_o;
  logic chan_a_interrupt_oe;
  logic chan_b_interrupt_o;
  logic chan_b_interrupt_oe;
  logic spare_output_a_n;
  logic spare_output_b_n;
  modport dev (
    input bus_sel, reg_addr, read_strobe_n, write_strobe_n, chan_a_select_n, chan_b_select_n,
    input data_host_o, data_host_oe,
    output data_dev_o, data_dev_oe, chan_a_interrupt_o, chan_a_interrupt_oe,
    output chan_b_interrupt_o, chan_b_interrupt_oe, spare_output_a_n, spare_output_b_n
  );
  modport host (
    output bus_sel, reg_addr, read_strobe_n, write_strobe_n, chan_a_select_n, chan_b_select_n,
    output data_host_o, data_host_oe,
    input data_dev_o, data_dev_oe, chan_a_interrupt_o, chan_a_interrupt_oe,
    input chan_b_interrupt_o, chan_b_interrupt_oe, spare_output_a_n, spare_output_b_n
  );
endinterface

// *** hdl/host_port_params.svh ***
// constants for the dual-channel parallel host bus port
// Functional notes
// [RL1] three-bit address picks register in channel
// [RL2] eight-bit bidirectional data bus, device drives reads
// [RL3] strobe style: read strobe fall reads, rise captures
// [RL4] strobe style: write latched at strobe rise
// [RL5] line style: host ties read strobe high
// [RL6] line style: write pin is direction, high reads
// [RL7] strobe style: separate per-channel active-low selects
// [RL8] line style: channel-A select is device select
// [RL9] line style: channel-B select picks channel
// [RL10] modem bit3 one: interrupt driven, spare low
// [RL11] modem bit3 zero: interrupt released, spare high
// [RL12] line style: shared open-drain active-low interrupt
// [RL13] channel B follows own bit3; line style zero
// [RL14] data bus released unless selected read
`ifndef HOST_PORT_PARAMS_SVH
`define HOST_PORT_PARAMS_SVH
`define HP_ADDR_W 3
`define HP_DATA_W 8
`define HP_NUM_REGS 8
`define HP_MCR_ADDR 3'h4
`define HP_MCR_IRQ_EN_BIT 3
`define HP_REG_RESET 8'h00
`define HP_STROBE_CYCLES 4
`define HP_GAP_CYCLES 2
`endif

// *** hdl/host_port_pkg.sv ***
// types for the host bus port; the host end uses the state type, the device end uses none
package host_port_pkg;
  typedef enum logic [1:0] {
    style_line = 2'h0, // read/write-line style, bus select low
    style_strobe = 2'h1 // strobe style, bus select high
  } bus_style_t;
  typedef enum logic [3:0] {
    st_idle = 4'h1,
    st_setup = 4'h2,
    st_strobe = 4'h4,
    st_gap = 4'h8
  } host_state_t;
endpackage

// *** hdl/pin_sync.sv ***
// three-stage input synchroniser with agreement-based change detection
`timescale 1ns/1ps
module pin_sync #(
  parameter int WIDTH = 1,
  parameter logic [WIDTH-1:0] RESET_VAL = '1
) (
  input wire logic i_ref_clk,
  input wire logic i_arst_n,
  input wire logic [WIDTH-1:0] i_pin,
  output logic [WIDTH-1:0] o_level
);
  logic [WIDTH-1:0] s1_reg, s2_reg, s3_reg, lvl_reg;
  logic [WIDTH-1:0] lvl_next;
  // a bit only changes once stages two and three agree
  always_comb begin
    lvl_next = lvl_reg;
    for (int i = 0; i < WIDTH; i++) begin
      if (s2_reg[i] == s3_reg[i]) begin
        lvl_next[i] = s3_reg[i];
      end
    end
  end
  // first stage feeds only the second
  always_ff @(posedge i_ref_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      s1_reg <= RESET_VAL;
      s2_reg <= RESET_VAL;
      s3_reg <= RESET_VAL;
      lvl_reg <= RESET_VAL;
    end else begin
      s1_reg <= i_pin;
      s2_reg <= s1_reg;
      s3_reg <= s2_reg;
      lvl_reg <= lvl_next;
    end
  end
  assign o_level = lvl_reg;
endmodule
